// file: src/mpt_timers.sv
// Prescalers, three 8-bit timers, flags, watchdog and pulse output.
// Assumes an APB master on pclk; subclock and event pin are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module mpt_timers (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        subclock_in,
   input  wire logic        event_in,
   input  wire logic        standby_mode,
   output logic [10:0]      serial_clock_taps,
   output logic             pulse_output_pin,
   output logic             pulse_output_oe,
   output logic             watchdog_reset
);
   import mpt_pkg::*;

   // ==========================================================
   // Bus decode
   logic [3:0] idx;
   logic       wr_en;
   logic       mapped;
   assign idx     = paddr[5:2];
   assign wr_en   = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign mapped  = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0);
   assign pslverr = psel && penable && !mapped;

   // ==========================================================
   // Registers written by software
   logic [3:0] port_function_select_a;
   logic [3:0] port_function_select_b;
   logic [3:0] first_timer_mode_reg;
   logic [3:0] second_timer_mode_reg;
   logic [3:0] third_timer_mode_reg;
   logic [7:0] second_load_reg;
   logic [7:0] third_load_reg;
   logic       watchdog_enable_flag;
   logic       stop_mode_reg;
   logic       watch_mode_reg;
   logic       second_load_strobe;
   logic       third_load_strobe;
   logic       tb_reset_strobe;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_function_select_a <= NIBBLE_RESET;
         port_function_select_b <= NIBBLE_RESET;
         first_timer_mode_reg   <= NIBBLE_RESET;
         second_timer_mode_reg  <= NIBBLE_RESET;
         third_timer_mode_reg   <= NIBBLE_RESET;
         watchdog_enable_flag   <= 1'b0;
         stop_mode_reg          <= 1'b0;
         watch_mode_reg         <= 1'b0;
      end else if (wr_en && mapped) begin
         case (idx)
            IDX_PORT_SEL_A:  port_function_select_a <= pwdata[3:0];
            IDX_PORT_SEL_B:  port_function_select_b <= pwdata[3:0];
            IDX_FIRST_MODE:  first_timer_mode_reg   <= pwdata[3:0];
            IDX_SECOND_MODE: second_timer_mode_reg  <= pwdata[3:0];
            IDX_THIRD_MODE:  third_timer_mode_reg   <= pwdata[3:0];
            IDX_CONTROL: begin
               watchdog_enable_flag <= pwdata[CTL_WDOG_BIT];
               stop_mode_reg        <= pwdata[CTL_STOP_BIT];
               watch_mode_reg       <= pwdata[CTL_WATCH_BIT];
            end
            default: ;
         endcase
      end
   end

   // High nibble write loads the counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         second_load_reg <= BYTE_RESET;
         third_load_reg  <= BYTE_RESET;
      end else if (wr_en && mapped) begin
         case (idx)
            IDX_SECOND_LOADL: second_load_reg[3:0] <= pwdata[3:0];
            IDX_SECOND_LOADH: second_load_reg[7:4] <= pwdata[3:0];
            IDX_THIRD_LOADL:  third_load_reg[3:0]  <= pwdata[3:0];
            IDX_THIRD_LOADH:  third_load_reg[7:4]  <= pwdata[3:0];
            default: ;
         endcase
      end
   end
   assign second_load_strobe = wr_en && mapped && (idx == IDX_SECOND_LOADH);
   assign third_load_strobe  = wr_en && mapped && (idx == IDX_THIRD_LOADH);
   // Counter-reset code clears in time-base mode
   assign tb_reset_strobe = wr_en && mapped && (idx == IDX_FIRST_MODE) &&
                            pwdata[TIME_BASE_BIT] && (pwdata[2:0] == TB_RESET_CODE);

   // ==========================================================
   // Input synchronisers: two last stages must agree
   logic [2:0] sub_sync;
   logic [2:0] evt_sync;
   logic       sub_level;
   logic       evt_level;
   logic       sub_rise;
   logic       evt_rise;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_sync  <= 3'h0;
         evt_sync  <= 3'h0;
         sub_level <= 1'b0;
         evt_level <= 1'b0;
      end else begin
         sub_sync <= {sub_sync[1:0], subclock_in};
         evt_sync <= {evt_sync[1:0], event_in};
         if (sub_sync[2] == sub_sync[1])
            sub_level <= sub_sync[2];
         if (evt_sync[2] == evt_sync[1])
            evt_level <= evt_sync[2];
      end
   end
   assign sub_rise = (sub_sync[2] == sub_sync[1]) && sub_sync[2] && !sub_level;
   // Event counted on falling edge, as the pin is active low
   assign evt_rise = (evt_sync[2] == evt_sync[1]) && !evt_sync[2] && evt_level;

   // ==========================================================
   // Prescalers
   logic [10:0] sys_prescale;
   logic [10:0] sys_tick;
   logic [2:0]  sub_div;
   logic [4:0]  sub_prescale;
   logic [4:0]  sub_tick;
   logic        sub_step;
   logic        halted;
   assign halted = stop_mode_reg || watch_mode_reg;
   // Clears on reset, counts from release
   // Halts in stop or watch mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sys_prescale <= PRESCALE_RESET;
      else if (!halted)
         sys_prescale <= sys_prescale + 11'h001;
   end
   // Tap pulses when bit i rises
   genvar gi;
   generate
      for (gi = 0; gi < 11; gi++) begin : g_sys_tap
         if (gi == 0) begin : g_first
            assign sys_tick[gi] = !halted && !sys_prescale[0];
         end else begin : g_rest
            assign sys_tick[gi] = !halted && (sys_prescale[gi-1:0] == {gi{1'b1}})
                                  && !sys_prescale[gi];
         end
      end
      for (gi = 0; gi < 5; gi++) begin : g_sub_tap
         if (gi == 0) begin : g_first
            assign sub_tick[gi] = sub_step && !sub_prescale[0];
         end else begin : g_rest
            assign sub_tick[gi] = sub_step && (sub_prescale[gi-1:0] == {gi{1'b1}})
                                  && !sub_prescale[gi];
         end
      end
   endgenerate
   assign serial_clock_taps = sys_prescale;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_div      <= 3'h0;
         sub_prescale <= 5'h00;
      end else if (tb_reset_strobe) begin
         sub_div      <= 3'h0;
         sub_prescale <= 5'h00;
      end else if (sub_rise) begin
         sub_div <= sub_div + 3'h1;
         if (sub_step)
            sub_prescale <= sub_prescale + 5'h01;
      end
   end
   assign sub_step = sub_rise && (sub_div == SUB_DIV_LAST);

   // ==========================================================
   // Clock selection, tap n pulses every 2^(n+1) cycles
   logic first_clk;
   logic second_clk;
   logic third_clk;
   always_comb begin
      first_clk = 1'b0;
      if (first_timer_mode_reg[TIME_BASE_BIT]) begin
         case (first_timer_mode_reg[2:0])
            3'h0: first_clk = sub_tick[4];
            3'h1: first_clk = sub_tick[3];
            3'h2: first_clk = sub_tick[2];
            3'h3: first_clk = sub_tick[0];
            3'h4: first_clk = sub_rise && sub_div[1:0] == 2'h3;
            default: first_clk = 1'b0;
         endcase
      end else begin
         case (first_timer_mode_reg[2:0])
            3'h0: first_clk = sys_tick[10];
            3'h1: first_clk = sys_tick[9];
            3'h2: first_clk = sys_tick[8];
            3'h3: first_clk = sys_tick[6];
            3'h4: first_clk = sys_tick[4];
            3'h5: first_clk = sys_tick[2];
            3'h6: first_clk = sys_tick[1];
            default: first_clk = sys_tick[0];
         endcase
      end
   end
   // Codes 0-6 divide, 7 external event
   always_comb begin
      case (second_timer_mode_reg[2:0])
         3'h0: second_clk = sys_tick[10];
         3'h1: second_clk = sys_tick[8];
         3'h2: second_clk = sys_tick[6];
         3'h3: second_clk = sys_tick[4];
         3'h4: second_clk = sys_tick[2];
         3'h5: second_clk = sys_tick[1];
         3'h6: second_clk = sys_tick[0];
         default: second_clk = evt_rise && port_function_select_a[EVENT_SEL_BIT];
      endcase
   end
   // Third timer: ratios past the shown codes reuse the fast taps
   always_comb begin
      case (third_timer_mode_reg[2:0])
         3'h0: third_clk = sys_tick[10];
         3'h1: third_clk = sys_tick[9];
         3'h2: third_clk = sys_tick[8];
         3'h3: third_clk = sys_tick[6];
         3'h4: third_clk = sys_tick[4];
         3'h5: third_clk = sys_tick[2];
         3'h6: third_clk = sys_tick[1];
         default: third_clk = sys_tick[0];
      endcase
   end

   // ==========================================================
   // Counters
   logic [7:0] first_count;
   logic [7:0] second_count;
   logic [7:0] third_count;
   logic       first_ovf;
   logic       second_ovf;
   logic       third_ovf;
   assign first_ovf  = first_clk && (first_count == COUNT_FULL);
   assign second_ovf = second_clk && (second_count == COUNT_FULL);
   assign third_ovf  = third_clk && (third_count == COUNT_FULL);
   // First counter wraps to zero after all ones; second and third reload the load value when auto-reload is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         first_count <= BYTE_RESET;
      else if (tb_reset_strobe)
         first_count <= BYTE_RESET;
      else if (first_clk)
         first_count <= first_count + 8'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         second_count <= BYTE_RESET;
      else if (second_load_strobe)
         second_count <= {pwdata[3:0], second_load_reg[3:0]};
      else if (second_ovf)
         second_count <= second_timer_mode_reg[AUTO_RELOAD_BIT] ? second_load_reg
                                                                : BYTE_RESET;
      else if (second_clk)
         second_count <= second_count + 8'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         third_count <= BYTE_RESET;
      else if (third_load_strobe)
         third_count <= {pwdata[3:0], third_load_reg[3:0]};
      else if (third_ovf)
         third_count <= third_timer_mode_reg[AUTO_RELOAD_BIT] ? third_load_reg
                                                              : BYTE_RESET;
      else if (third_clk)
         third_count <= third_count + 8'h01;
   end

   // ==========================================================
   // Interrupt request flags; set wins over a same-cycle clear
   logic first_timer_irq_flag;
   logic second_timer_irq_flag;
   logic third_timer_irq_flag;
   logic clr1;
   logic clr2;
   assign clr1 = wr_en && mapped && (idx == IDX_FLAG_WORD1);
   assign clr2 = wr_en && mapped && (idx == IDX_FLAG_WORD2);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_timer_irq_flag  <= 1'b0;
         second_timer_irq_flag <= 1'b0;
         third_timer_irq_flag  <= 1'b0;
      end else begin
         if (first_ovf)
            first_timer_irq_flag <= 1'b1;
         else if (clr1)
            first_timer_irq_flag <= pwdata[FIRST_IRQ_BIT];
         if (second_ovf)
            second_timer_irq_flag <= 1'b1;
         else if (clr2)
            second_timer_irq_flag <= pwdata[SECOND_IRQ_BIT];
         if (third_ovf)
            third_timer_irq_flag <= 1'b1;
         else if (clr2)
            third_timer_irq_flag <= pwdata[THIRD_IRQ_BIT];
      end
   end

   // ==========================================================
   // Watchdog and pulse output
   // Overflow with watchdog on resets device
   // No clock tick, no overflow, no reset
   // Standby does not gate the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         watchdog_reset <= 1'b0;
      else
         watchdog_reset <= third_ovf && watchdog_enable_flag;
   end
   // Without auto-reload, high from load value until wrap
   // Holds level while timer is stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pulse_output_pin <= 1'b0;
      else if (third_ovf)
         pulse_output_pin <= 1'b0;
      // Loading puts the count at the load value, so the high phase starts
      else if (third_load_strobe)
         pulse_output_pin <= 1'b1;
      else if (third_clk && (third_count + 8'h01 == third_load_reg))
         pulse_output_pin <= 1'b1;
   end
   assign pulse_output_oe = port_function_select_b[PULSE_SEL_BIT];

   // ==========================================================
   // Read data: mode registers read as zero; load addresses return the counter nibbles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         case (paddr[5:2])
            IDX_PORT_SEL_A:   prdata[3:0] <= port_function_select_a;
            IDX_PORT_SEL_B:   prdata[3:0] <= port_function_select_b;
            IDX_FLAG_WORD1:   prdata[FIRST_IRQ_BIT] <= first_timer_irq_flag;
            IDX_FLAG_WORD2: begin
               prdata[SECOND_IRQ_BIT] <= second_timer_irq_flag;
               prdata[THIRD_IRQ_BIT]  <= third_timer_irq_flag;
            end
            IDX_SECOND_LOADL: prdata[3:0] <= second_count[3:0];
            IDX_SECOND_LOADH: prdata[3:0] <= second_count[7:4];
            IDX_THIRD_LOADL:  prdata[3:0] <= third_count[3:0];
            IDX_THIRD_LOADH:  prdata[3:0] <= third_count[7:4];
            IDX_CONTROL:      prdata[2:0] <= {watch_mode_reg, stop_mode_reg,
                                              watchdog_enable_flag};
            default: ;
         endcase
      end
   end
   logic unused_standby;
   assign unused_standby = standby_mode;

   // ==========================================================
   // Checks
   AST_FIRST_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      first_ovf |=> first_timer_irq_flag) else $error("first flag not set");
   AST_SECOND_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      second_ovf |=> second_timer_irq_flag) else $error("second flag not set");
   AST_THIRD_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      third_ovf |=> third_timer_irq_flag) else $error("third flag not set");
   AST_FIRST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
      first_ovf && !tb_reset_strobe |=> first_count == 8'h00) else $error("no wrap");
   AST_SECOND_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
      second_ovf && !second_load_strobe |=> second_count ==
      (($past(second_timer_mode_reg[3])) ? $past(second_load_reg) : 8'h00))
      else $error("bad reload");
   AST_LOAD_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
      third_load_strobe |=> third_count == third_load_reg)
      else $error("load missed");
   AST_WATCHDOG: assert property (@(posedge pclk) disable iff (!presetn)
      third_ovf && watchdog_enable_flag |=> watchdog_reset)
      else $error("watchdog missed");
   AST_PRESCALE_HALT: assert property (@(posedge pclk) disable iff (!presetn)
      halted |=> $stable(sys_prescale)) else $error("prescaler ran");
endmodule
`default_nettype wire

// file: src/mpt_pkg.sv
// Constants for the prescaler and timer block.
// Assumes an APB slave with 32-bit data; registers sit in the low nibble.
package mpt_pkg;
   // ==========================================================
   // Register word indices, decoded from paddr[5:2] (byte address is four times the index)
   localparam logic [3:0] IDX_PORT_SEL_A   = 4'h4;
   localparam logic [3:0] IDX_FIRST_MODE   = 4'h8;
   localparam logic [3:0] IDX_SECOND_MODE  = 4'h9;
   localparam logic [3:0] IDX_SECOND_LOADL = 4'hA;
   localparam logic [3:0] IDX_SECOND_LOADH = 4'hB;
   localparam logic [3:0] IDX_THIRD_MODE   = 4'hD;
   localparam logic [3:0] IDX_THIRD_LOADL  = 4'hE;
   localparam logic [3:0] IDX_THIRD_LOADH  = 4'hF;
   localparam logic [3:0] IDX_FLAG_WORD1   = 4'h1;
   localparam logic [3:0] IDX_FLAG_WORD2   = 4'h2;
   localparam logic [3:0] IDX_PORT_SEL_B   = 4'h5;
   localparam logic [3:0] IDX_CONTROL      = 4'h6;
   // ==========================================================
   // Field positions
   localparam int TIME_BASE_BIT   = 3;
   localparam int AUTO_RELOAD_BIT = 3;
   localparam int FIRST_IRQ_BIT   = 2;
   localparam int SECOND_IRQ_BIT  = 0;
   localparam int THIRD_IRQ_BIT   = 2;
   localparam int PULSE_SEL_BIT   = 2;
   localparam int EVENT_SEL_BIT   = 3;
   localparam int CTL_WDOG_BIT    = 0;
   localparam int CTL_STOP_BIT    = 1;
   localparam int CTL_WATCH_BIT   = 2;
   // ==========================================================
   // Reset values and codes
   localparam logic [3:0]  NIBBLE_RESET   = 4'h0;
   localparam logic [7:0]  BYTE_RESET     = 8'h00;
   localparam logic [10:0] PRESCALE_RESET = 11'h000;
   localparam logic [7:0]  COUNT_FULL     = 8'hFF;
   localparam logic [2:0]  EVENT_CODE     = 3'h7;
   localparam logic [2:0]  TB_RESET_CODE  = 3'h6;
   localparam logic [2:0]  SUB_DIV_LAST   = 3'h7;
   localparam logic [2:0]  SYNC_SHIFT     = 3'h7;
endpackage

// file: sim/mpt_cpu_model.sv
// Bus master model of the CPU core that programs the timer block.
// Assumes a free-running pclk; the slave may stretch the access phase.
`timescale 1ns/100ps
`default_nettype none
module mpt_cpu_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [31:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // ==========================================================
   // Idle bus
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 32'h00000000;
      pwdata  = 32'h00000000;
   end
   // ==========================================================
   // One transfer; waits for the answer, timeout lives in the bench
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic load(input logic [31:0] lo_addr, input logic [7:0] v);
      logic [31:0] rd;
      logic        err;
      xfer(1'b1, lo_addr, {28'h0000000, v[3:0]}, rd, err);
      xfer(1'b1, lo_addr + 32'h00000004, {28'h0000000, v[7:4]}, rd, err);
   endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the prescaler and timer block.
// Assumes the CPU model drives the register bus; subclock runs free.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import mpt_pkg::*;
   logic pclk, presetn, subclock_in, event_in, standby_mode;
   logic psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, v;
   logic [10:0] serial_clock_taps, t0;
   logic pulse_output_pin, pulse_output_oe, watchdog_reset, e;
   int fail_count = 0;
   int tests_run  = 0;
   int wd_count   = 0;
   int hi_count   = 0;
   int w0, h0;
   mpt_timers mpt_timers_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .subclock_in(subclock_in), .event_in(event_in),
      .standby_mode(standby_mode), .serial_clock_taps(serial_clock_taps),
      .pulse_output_pin(pulse_output_pin), .pulse_output_oe(pulse_output_oe),
      .watchdog_reset(watchdog_reset));
   mpt_cpu_model cpu_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // ==========================================================
   // Clocks and monitors
   always #4 pclk = ~pclk;
   always #500 subclock_in = ~subclock_in;
   always @(posedge pclk) begin
      if (watchdog_reset === 1'b1) wd_count <= wd_count + 1;
      if (pulse_output_pin === 1'b1) hi_count <= hi_count + 1;
   end
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      cpu_i.xfer(1'b1, {26'h0, idx, 2'b00}, d, v, e);
   endtask
   task automatic rd(input logic [3:0] idx);
      cpu_i.xfer(1'b0, {26'h0, idx, 2'b00}, 32'h0, v, e);
   endtask
   task automatic tally_and_finish();
      $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic run_prescaler();
      @(posedge pclk);
      #1 t0 = serial_clock_taps;
      repeat (10) @(posedge pclk);
      #1 check({21'h0, serial_clock_taps}, {21'h0, t0 + 11'h00A});
   endtask
   task automatic run_first();
      // event pin routed before any event clocking
      wr(IDX_PORT_SEL_A, 32'h00000008);
      wr(IDX_FIRST_MODE, 32'h0000000E);
      wr(IDX_FIRST_MODE, 32'h00000007);
      wr(IDX_FLAG_WORD1, 32'h00000000);
      repeat (400) @(posedge pclk);
      rd(IDX_FLAG_WORD1);
      check({31'h0, v[FIRST_IRQ_BIT]}, 32'h0);
      repeat (200) @(posedge pclk);
      rd(IDX_FLAG_WORD1);
      check({31'h0, v[FIRST_IRQ_BIT]}, 32'h1);
   endtask
   task automatic run_second();
      wr(IDX_SECOND_MODE, 32'h0000000E);
      cpu_i.load({26'h0, IDX_SECOND_LOADL, 2'b00}, 8'hF0);
      wr(IDX_FLAG_WORD2, 32'h00000000);
      rd(IDX_SECOND_LOADH);
      check({28'h0, v[3:0]}, 32'hF);
      repeat (5) @(posedge pclk);
      rd(IDX_FLAG_WORD2);
      check({31'h0, v[SECOND_IRQ_BIT]}, 32'h0);
      repeat (30) @(posedge pclk);
      rd(IDX_FLAG_WORD2);
      check({31'h0, v[SECOND_IRQ_BIT]}, 32'h1);
      rd(IDX_SECOND_LOADH);
      check({28'h0, v[3:0]}, 32'hF);
   endtask
   task automatic run_third();
      standby_mode <= 1'b1;
      wr(IDX_PORT_SEL_B, 32'h00000004);
      #1 check({31'h0, pulse_output_oe}, 32'h1);
      wr(IDX_CONTROL, 32'h00000001);
      wr(IDX_THIRD_MODE, 32'h00000007);
      w0 = wd_count;
      h0 = hi_count;
      cpu_i.load({26'h0, IDX_THIRD_LOADL, 2'b00}, 8'hF0);
      repeat (60) @(posedge pclk);
      #1 check(32'(wd_count - w0), 32'h1);
      check({31'h0, hi_count != h0}, 32'h1);
      check({31'h0, pulse_output_pin}, 32'h0);
      rd(IDX_FLAG_WORD2);
      check({31'h0, v[THIRD_IRQ_BIT]}, 32'h1);
      // Window long enough for a missed stop to overflow
      wr(IDX_CONTROL, 32'h00000003);
      @(posedge pclk);
      #1 t0 = serial_clock_taps;
      w0 = wd_count;
      h0 = hi_count;
      repeat (600) @(posedge pclk);
      #1 check({21'h0, serial_clock_taps}, {21'h0, t0});
      check(32'(wd_count - w0), 32'h0);
      check(32'(hi_count - h0), 32'h0);
      wr(IDX_CONTROL, 32'h00000000);
   endtask
   task automatic run_bus();
      rd(IDX_FIRST_MODE);
      check(v, 32'h0);
      rd(IDX_SECOND_MODE);
      check(v, 32'h0);
      cpu_i.xfer(1'b0, 32'h00000040, 32'h0, v, e);
      check({31'h0, e}, 32'h1);
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      subclock_in = 1'b0;
      event_in = 1'b0;
      standby_mode = 1'b0;
      repeat (11) @(posedge pclk);
      #1 check({21'h0, serial_clock_taps}, 32'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      run_prescaler();
      run_first();
      run_second();
      run_third();
      run_bus();
      tally_and_finish();
   end
   initial begin
      #200000;
      fail_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
